// [src/hfc_pkg.sv]
/*
 * package for the host interface completion state machine: states, flag bundle,
 * response buffer sizes and the idle read value.
 * assumes a single clock domain and byte-wide data window accesses.
 */
package hfc_pkg;
	localparam int HFC_DATA_W = 8;
	localparam int HFC_RSP_DEPTH = 16;
	localparam int HFC_PTR_W = 5;
	localparam int HFC_FIFO_DEPTH = 4;
	localparam logic [7:0] HFC_IDLE_READ = 8'hff;
	localparam logic [4:0] HFC_PTR_RESET = 5'h00;

	typedef enum logic [1:0] {
		HFC_IDLE,
		HFC_EXECUTION,
		HFC_COMPLETION
	} hfc_state_t;

	// status request bits, one set per write
	typedef struct packed {
		logic accept_command;
		logic execute_request_bit;
		logic response_retry;
	} hfc_request_t;

	typedef struct packed {
		logic command_ready;
		logic response_available_flag;
		logic expect_data;
	} hfc_flags_t;
endpackage

// [src/hfc_fifo.sv]
/*
 * small valid/ready fifo for read data from the data window.
 * assumes one clock, synchronous active high reset.
 */
`timescale 1ns/1ns
module hfc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// fill side
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// drain side
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid_in && (count != (AW+1)'(DEPTH));
	wire pop = out_ready_in && (count != '0);

	assign in_ready_out = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out = mem[rd_ptr];

	always_ff @(posedge clk_in)
	begin
		if (push)
			mem[wr_ptr] <= in_data_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // hfc_fifo

// [src/hfc_completion.sv]
/*
 * completion phase of the host interface status state machine: response
 * draining through the data window, retry, execute ignore and accept to idle.
 * assumes host accesses are single-cycle strobes on clk_in and that the
 * execution engine loads the response buffer before pulsing exec_done_in.
 */
`timescale 1ns/1ns
// Functional notes
// - in completion with data available, each non-final read taken while the fifo has room returns next byte
// - reading final byte clears response available, stays in completion
// - retry after drain rewinds read pointer and sets response available again
// - execute request in completion with no data left is ignored
// - accept command with no data left goes idle, all flags zero
// - drained completion discards data writes and reads return ff
// - execution finishing enters completion with response available set
module hfc_completion
	import hfc_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// execution engine side
	input wire logic exec_start_in,
	input wire logic exec_done_in,
	input wire logic [HFC_PTR_W-1:0] rsp_len_in,
	input wire logic rsp_wr_in,
	input wire logic [HFC_PTR_W-2:0] rsp_wr_addr_in,
	input wire logic [HFC_DATA_W-1:0] rsp_wr_data_in,
	// status register writes
	input wire logic sts_wr_in,
	input wire hfc_request_t sts_req_in,
	// data window accesses
	input wire logic data_wr_in,
	input wire logic data_rd_in,
	// read data stream
	output logic rd_valid_out,
	output logic [HFC_DATA_W-1:0] rd_data_out,
	input wire logic rd_ready_in,
	output logic rd_ready_out,
	// status view
	output hfc_state_t state_out,
	output hfc_flags_t flags_out
);
	logic [HFC_DATA_W-1:0] rsp_mem [HFC_RSP_DEPTH];
	hfc_state_t state;
	hfc_state_t next_state;
	logic avail;
	logic next_avail;
	logic [HFC_PTR_W-1:0] response_read_pointer;
	logic [HFC_PTR_W-1:0] next_ptr;
	logic [HFC_PTR_W-1:0] rsp_len;
	logic fifo_ready;
	logic fifo_valid;
	logic [HFC_DATA_W-1:0] fifo_data;

	// several request bits at once are undefined; such a write counts as no request
	function automatic logic single_req(input logic wr, input hfc_request_t req,
		input logic sel);
		return wr && $onehot(req) && sel;
	endfunction

	// request decode
	wire req_retry = single_req(sts_wr_in, sts_req_in, sts_req_in.response_retry);
	wire req_accept = single_req(sts_wr_in, sts_req_in, sts_req_in.accept_command);
	wire req_exec = single_req(sts_wr_in, sts_req_in, sts_req_in.execute_request_bit);

	// a read is only taken while the fifo can hold its answer
	wire rd_take = data_rd_in && fifo_ready;
	wire in_compl = (state == HFC_COMPLETION);
	wire drain_rd = rd_take && in_compl && avail;
	wire [HFC_PTR_W-1:0] ptr_inc = response_read_pointer + 1'b1;
	wire last_rd = drain_rd && (ptr_inc >= rsp_len);
	wire [HFC_PTR_W-2:0] rd_index = response_read_pointer[HFC_PTR_W-2:0];
	wire [HFC_DATA_W-1:0] rd_byte = drain_rd ? rsp_mem[rd_index] : HFC_IDLE_READ;
	// execute requests and data writes change nothing once drained
	wire hold_req = in_compl && !avail && (req_exec || data_wr_in);

	// completion phase transitions
	always_comb
	begin
		next_state = state;
		next_avail = avail;
		next_ptr = response_read_pointer;
		unique case (state)
			HFC_IDLE:
			begin
				if (exec_start_in)
					next_state = HFC_EXECUTION;
			end
			HFC_EXECUTION:
			begin
				if (exec_done_in)
				begin
					next_state = HFC_COMPLETION;
					next_avail = 1'b1;
					next_ptr = HFC_PTR_RESET;
				end
			end
			HFC_COMPLETION:
			begin
				if (drain_rd)
					next_ptr = ptr_inc;
				if (last_rd)
					next_avail = 1'b0;
				if (hold_req)
					next_state = HFC_COMPLETION;
				// retry and accept only count once the response is drained
				if (!avail && req_retry)
				begin
					next_ptr = HFC_PTR_RESET;
					next_avail = 1'b1;
				end
				else if (!avail && req_accept)
				begin
					next_state = HFC_IDLE;
					next_avail = 1'b0;
				end
			end
			default:
			begin
				next_state = HFC_IDLE;
				next_avail = 1'b0;
			end
		endcase
	end

	// the engine fills the response buffer while executing
	always_ff @(posedge clk_in)
	begin
		if (rsp_wr_in)
			rsp_mem[rsp_wr_addr_in] <= rsp_wr_data_in;
	end

	// state, flag and read pointer
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			state <= HFC_IDLE;
			avail <= 1'b0;
			response_read_pointer <= HFC_PTR_RESET;
		end
		else
		begin
			state <= next_state;
			avail <= next_avail;
			response_read_pointer <= next_ptr;
		end
	end

	// response length is latched as execution ends
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rsp_len <= HFC_PTR_RESET;
		else if (exec_done_in && state == HFC_EXECUTION)
			rsp_len <= rsp_len_in;
	end

	// the output stage loads from the fifo when it is empty or its byte is consumed;
	// the same condition pops the fifo so that each byte leaves once
	wire out_load = fifo_valid && (!rd_valid_out || rd_ready_in);

	// read answers queue here so the host may read every cycle
	hfc_fifo #(
		.WIDTH(HFC_DATA_W),
		.DEPTH(HFC_FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.in_valid_in(rd_take),
		.in_data_in(rd_byte),
		.in_ready_out(fifo_ready),
		.out_valid_out(fifo_valid),
		.out_data_out(fifo_data),
		.out_ready_in(out_load)
	);

	// read byte stands until the consumer takes it
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rd_valid_out <= 1'b0;
		else if (out_load)
			rd_valid_out <= 1'b1;
		else if (rd_ready_in)
			rd_valid_out <= 1'b0;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rd_data_out <= '0;
		else if (out_load)
			rd_data_out <= fifo_data;
	end

	// fifo room, one cycle late; reads beyond it are dropped
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rd_ready_out <= 1'b0;
		else
			rd_ready_out <= fifo_ready;
	end

	// status view shows the state and flag after each edge
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			state_out <= HFC_IDLE;
			flags_out <= '0;
		end
		else
		begin
			state_out <= next_state;
			flags_out <= '{command_ready: 1'b0, response_available_flag: next_avail,
				expect_data: 1'b0};
		end
	end
endmodule // hfc_completion

// [sim/hfc_completion_checker.sv]
/* completion phase assertions on the ports of hfc_completion.
   assumes one clock and a synchronous active high reset. */
`timescale 1ns/1ns
module hfc_completion_checker
	import hfc_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// requests
	input wire logic exec_done_in,
	input wire logic sts_wr_in,
	input wire hfc_request_t sts_req_in,
	input wire logic data_wr_in,
	input wire logic data_rd_in,
	// status
	input wire hfc_state_t state_out,
	input wire hfc_flags_t flags_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wire cmp = state_out == HFC_COMPLETION;
	wire av = flags_out.response_available_flag;
	wire dr = cmp && !av && !exec_done_in && !data_rd_in;
	a_done_enters: assert property (exec_done_in && state_out == HFC_EXECUTION |=> cmp && av)
		else $error("no completion entry");
	a_read_stays: assert property (data_rd_in && cmp && av && !sts_wr_in |=> cmp)
		else $error("read left completion");
	a_last_clears: assert property (!$past(rst_in) && $fell(av) |-> cmp && flags_out == 3'h0)
		else $error("bad drain");
	a_retry_rearms: assert property (sts_wr_in && sts_req_in == 3'h1 && dr |=> cmp && av)
		else $error("retry not taken");
	a_exec_ignored: assert property (sts_wr_in && sts_req_in == 3'h2 && dr
		|=> $stable(state_out) && $stable(flags_out))
		else $error("execute not ignored");
	a_accept_idles: assert property (sts_wr_in && sts_req_in == 3'h4 && dr
		|=> state_out == HFC_IDLE && flags_out == 3'h0)
		else $error("accept not idle");
	a_write_dropped: assert property (data_wr_in && dr && !sts_wr_in
		|=> $stable(state_out) && $stable(flags_out))
		else $error("write not dropped");
	c_retry: cover property (sts_wr_in && sts_req_in == 3'h1 && dr);
	c_accept: cover property (sts_wr_in && sts_req_in == 3'h4 && dr);
	c_drain: cover property ($fell(av));
endmodule // hfc_completion_checker

bind hfc_completion hfc_completion_checker i_chk (.clk_in(clk_in), .rst_in(rst_in),
	.exec_done_in(exec_done_in), .sts_wr_in(sts_wr_in), .sts_req_in(sts_req_in),
	.data_wr_in(data_wr_in), .data_rd_in(data_rd_in), .state_out(state_out),
	.flags_out(flags_out));

// [sim/hfc_host_model.sv]
/* host software model: status writes, data window accesses, read data sink.
   assumes requests are taken at the rising edge of clk_in. */
`timescale 1ns/1ns
module hfc_host_model
	import hfc_pkg::*;
(
	// clock
	input wire logic clk_in,
	// read data
	input wire logic rd_valid_in,
	input wire logic [HFC_DATA_W-1:0] rd_data_in,
	// accesses
	output logic sts_wr_out,
	output hfc_request_t sts_req_out,
	output logic data_wr_out,
	output logic data_rd_out,
	output logic rd_ready_out
);
	logic stall = 1'b0;
	initial {sts_wr_out, sts_req_out, data_wr_out, data_rd_out} = 6'h0;
	assign rd_ready_out = !stall;
	// one request bit per write; released lines show the inverse
	task automatic sts(input hfc_request_t r);
		@(negedge clk_in) {sts_wr_out, sts_req_out} = {1'b1, r};
		@(negedge clk_in) {sts_wr_out, sts_req_out} = {1'b0, ~r};
	endtask
	task automatic pulse(input logic rd);
		@(negedge clk_in) {data_rd_out, data_wr_out} = {rd, !rd};
		@(negedge clk_in) {data_rd_out, data_wr_out} = 2'h0;
	endtask
	task automatic rd(output logic [HFC_DATA_W-1:0] b);
		int n;
		pulse(1'b1);
		for (n = 0; n < 8 && rd_valid_in !== 1'b1; n++) @(negedge clk_in);
		b = rd_valid_in ? rd_data_in : 'x;
	endtask
endmodule // hfc_host_model

// [sim/hfc_completion_tb.sv]
/* bench for hfc_completion: engine stimulus, host model and checks.
   assumes the checker binds itself to the design. */
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module hfc_completion_tb import hfc_pkg::*;;
	logic clk_in = 1'b0, rst_in = 1'b1, go = 1'b0, done = 1'b0, rsp_wr = 1'b0;
	logic [4:0] len = 5'h0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdat = 8'h0, b, rd_data_out;
	logic sts_wr, data_wr, data_rd, rd_ready, rd_valid_out, rd_ready_out;
	hfc_request_t req;
	hfc_state_t state_out;
	hfc_flags_t flags_out;
	int err_count = 0, cmp_count = 0, i;
	always #5 clk_in = ~clk_in;
	hfc_completion i_dut (.clk_in, .rst_in, .exec_start_in(go), .exec_done_in(done),
		.rsp_len_in(len), .rsp_wr_in(rsp_wr), .rsp_wr_addr_in(addr), .rsp_wr_data_in(wdat),
		.sts_wr_in(sts_wr), .sts_req_in(req), .data_wr_in(data_wr), .data_rd_in(data_rd),
		.rd_valid_out, .rd_data_out, .rd_ready_in(rd_ready), .rd_ready_out, .state_out,
		.flags_out);
	hfc_host_model i_host (.clk_in, .rd_valid_in(rd_valid_out), .rd_data_in(rd_data_out),
		.sts_wr_out(sts_wr), .sts_req_out(req), .data_wr_out(data_wr),
		.data_rd_out(data_rd), .rd_ready_out(rd_ready));
	task automatic conclude;
		$display("mismatches %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// engine: start, load n bytes 30h upward, finish
	task automatic run(input int n);
		int k;
		@(negedge clk_in) go = 1'b1;
		@(negedge clk_in) go = 1'b0;
		for (k = 0; k < n; k++)
		begin
			rsp_wr = 1'b1;
			addr = 4'(k);
			wdat = 8'(8'h30 + k);
			@(negedge clk_in);
		end
		rsp_wr = 1'b0;
		len = 5'(n);
		done = 1'b1;
		@(negedge clk_in) done = 1'b0;
	endtask
	initial
	begin
		repeat (20) @(negedge clk_in);
		rst_in = 1'b0;
		run(3);
		`CHK({state_out, flags_out}, {HFC_COMPLETION, 3'h2})
		for (i = 0; i < 3; i++)
		begin
			i_host.rd(b);
			`CHK({b, flags_out}, {8'(8'h30 + i), i < 2 ? 3'h2 : 3'h0})
		end
		i_host.rd(b);
		`CHK(b, HFC_IDLE_READ)
		i_host.pulse(1'b0);
		`CHK({state_out, flags_out}, {HFC_COMPLETION, 3'h0})
		i_host.sts(3'h2);
		`CHK({state_out, flags_out}, {HFC_COMPLETION, 3'h0})
		i_host.sts(3'h1);
		`CHK(flags_out, 3'h2)
		for (i = 0; i < 3; i++)
		begin
			i_host.rd(b);
			`CHK({b, flags_out}, {8'(8'h30 + i), i < 2 ? 3'h2 : 3'h0})
		end
		i_host.sts(3'h4);
		`CHK({state_out, flags_out}, {HFC_IDLE, 3'h0})
		run(16);
		`CHK({state_out, flags_out}, {HFC_COMPLETION, 3'h2})
		i_host.stall = 1'b1;
		repeat (6) i_host.pulse(1'b1);
		`CHK({rd_ready_out, rd_valid_out, rd_data_out}, {2'h1, 8'h30})
		i_host.stall = 1'b0;
		for (i = 1; i < 5; i++)
		begin
			@(negedge clk_in);
			`CHK({rd_valid_out, rd_data_out}, {1'b1, 8'(8'h30 + i)})
		end
		repeat (4) @(negedge clk_in);
		`CHK(rd_valid_out, 1'b0)
		conclude;
	end
	// tests need about a hundred cycles
	initial
	begin
		#20000;
		err_count++;
		conclude;
	end
endmodule // hfc_completion_tb
